// ### core/flash_cmd_pkg.sv
// constants shared by the serial flash instruction handler
package flash_cmd_pkg;
  // clock rate of mclk_i
  localparam int CLK_MHZ = 20;
  // fixed opcodes
  localparam logic [7:0] OP_CONT_PROG = 8'had;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_SEC_RD = 8'h2b;
  localparam logic [7:0] OP_ID_PAIR = 8'h90;
  localparam logic [7:0] OP_ID_PAIR2 = 8'hef;
  localparam logic [7:0] OP_ID_PAIR4 = 8'hdf;
  // defaults for the configurable opcodes
  localparam logic [7:0] DEF_OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] DEF_OP_SLEEP = 8'hb9;
  localparam logic [7:0] DEF_OP_WAKE = 8'hab;
  localparam logic [7:0] DEF_OP_SIG = 8'hab;
  localparam logic [7:0] DEF_OP_OTP_IN = 8'hb1;
  localparam logic [7:0] DEF_OP_OTP_OUT = 8'hc1;
  localparam logic [7:0] DEF_OP_RB_EN = 8'h70;
  localparam logic [7:0] DEF_OP_RB_DIS = 8'h80;
  localparam logic [7:0] DEF_OP_SR_WR = 8'h01;
  localparam logic [7:0] DEF_OP_SEC_WR = 8'h2f;
  // identity values, arbitrary
  localparam logic [7:0] DEF_SIG_ID = 8'h3a;
  localparam logic [7:0] DEF_MAN_ID = 8'h7e;
  localparam logic [7:0] DEF_DEV_ID = 8'h41;
  // id address that puts the device id first
  localparam logic [7:0] ID_ADDR_DEV_FIRST = 8'h01;
  // frame byte positions
  localparam logic [3:0] HDR_FIRST = 4'd4;
  localparam logic [3:0] HDR_NEXT = 4'd1;
  localparam logic [3:0] TX_START_REG = 4'd1;
  localparam logic [3:0] TX_START_ID = 4'd4;
  localparam logic [3:0] SIG_DONE_BYTES = 4'd5;
  // security register bit positions
  localparam int SEC_CP_BIT = 4;
  localparam int SEC_LOCK_BIT = 1;
  localparam int SEC_FACTORY_BIT = 0;
  // reset values
  localparam logic [2:0] PIN_RST = 3'b100;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  // timing: entry is a least time (round up), wake a longest time (round down)
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_NS = 8800;
  localparam int SLEEP_RAW = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_RAW = (WAKE_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] SLEEP_ENTRY_CYC = 12'((SLEEP_RAW < 1) ? 1 : SLEEP_RAW);
  localparam logic [11:0] WAKE_CYC = 12'((WAKE_RAW < 1) ? 1 : WAKE_RAW);
  // power states
  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_DEEP = 2'b10,
    PWR_WAKING = 2'b11
  } power_type;
endpackage : flash_cmd_pkg

// ### core/flash_cmd_core.sv
// serial flash instruction handler: pair program mode, deep sleep, ids, otp
//
// Summary of operation
// R1: pair program needs write enable latch set
// R2: two data bytes, first even, second odd
// R3: one data byte only: nothing programmed
// R4: bytes beyond the second are dropped
// R5: protected target ignored, latch kept
// R6: address steps by two after each pair
// R7: no wrap; last address ends mode, clears latch
// R8: pair mode accepts only four opcodes
// R9: write disable in pair mode waits idle
// R10: host frames first pair, then opcode-only pairs
// R11: host waits for write completion between frames
// R12: ready busy drives serial out while selected in pair mode
// R13: ready busy enable/disable refused in pair mode
// R14: deep sleep entered after entry delay
// R15: asleep: only wake and signature accepted
// R16: wake needs select rise after eight bits
// R17: standby returns after wake delay
// R18: no wake or signature during write
// R19: signature repeats; ends after one full byte
// R20: id read: dummy, dummy, address, then ids
// R21: address one puts device id first; alternate
// R22: otp enter redirects accesses, exit restores
// R23: otp refuses register writes; locked means reads
// R24: security bit four shows pair mode
// R25: unlisted opcodes are parameters
`timescale 1ns/10ps
module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] WRITE_ENABLE_CMD_OP = DEF_OP_WRITE_ENABLE_CMD,
  parameter logic [7:0] SLEEP_OP = DEF_OP_SLEEP,
  parameter logic [7:0] WAKE_OP = DEF_OP_WAKE,
  parameter logic [7:0] SIG_OP = DEF_OP_SIG,
  parameter logic [7:0] OTP_IN_OP = DEF_OP_OTP_IN,
  parameter logic [7:0] OTP_OUT_OP = DEF_OP_OTP_OUT,
  parameter logic [7:0] RB_EN_OP = DEF_OP_RB_EN,
  parameter logic [7:0] RB_DIS_OP = DEF_OP_RB_DIS,
  parameter logic [7:0] SR_WR_OP = DEF_OP_SR_WR,
  parameter logic [7:0] SEC_WR_OP = DEF_OP_SEC_WR,
  parameter logic [7:0] SIG_ID = DEF_SIG_ID,
  parameter logic [7:0] MAN_ID = DEF_MAN_ID,
  parameter logic [7:0] DEV_ID = DEF_DEV_ID
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  input wire logic write_in_progress_i,
  input wire logic wel_clear_i,
  input wire logic area_protected_i,
  input wire logic [23:0] last_unprotected_addr_i,
  input wire logic otp_locked_i,
  input wire logic otp_factory_lock_i,
  input wire logic [7:0] status_byte_i,
  output logic [23:0] target_addr_o,
  output logic prog_req_o,
  output logic [23:0] prog_addr_o,
  output logic [15:0] prog_data_o,
  output logic status_write_req_o,
  output logic [7:0] reg_wdata_o,
  output logic sec_write_req_o,
  output logic write_enable_latch_o,
  output logic cp_mode_o,
  output logic ready_busy_en_o,
  output logic otp_mode_o,
  output logic deep_sleep_o,
  output logic [7:0] security_reg_o
);

  // configurable opcodes must not shadow the fixed ones
  if (WRITE_ENABLE_CMD_OP == OP_CONT_PROG || SLEEP_OP == OP_CONT_PROG || WAKE_OP == OP_STATUS_RD) begin : g_bad_op
    $error("configurable opcode collides with a fixed opcode");
  end

  // id opcode test, used by decoder and output mux
  function automatic logic is_id(input logic [7:0] op);
    is_id = (op == OP_ID_PAIR) || (op == OP_ID_PAIR2) || (op == OP_ID_PAIR4);
  endfunction : is_id

  // instruction acceptance for the present mode
  function automatic logic cmd_ok(input logic [7:0] op, input logic cp, input logic asleep,
                                  input logic waking, input logic write_in_progress, input logic otp, input logic locked);
    logic known;
    logic ok;
    known = (op == OP_CONT_PROG) || (op == OP_WRITE_DIS) || (op == OP_STATUS_RD) || (op == OP_SEC_RD)
            || (op == WRITE_ENABLE_CMD_OP) || (op == SLEEP_OP) || (op == WAKE_OP) || (op == SIG_OP) || is_id(op)
            || (op == OTP_IN_OP) || (op == OTP_OUT_OP) || (op == RB_EN_OP) || (op == RB_DIS_OP)
            || (op == SR_WR_OP) || (op == SEC_WR_OP);
    if (waking) begin
      ok = 1'b0; // host keeps select high while waking
    end else if (asleep) begin
      ok = ((op == WAKE_OP) || (op == SIG_OP)) && !write_in_progress; // R15 R18
    end else if (cp) begin
      // busy pairs and disable wait for idle; enable/disable of ready busy excluded
      ok = (((op == OP_CONT_PROG) || (op == OP_WRITE_DIS)) && !write_in_progress)
           || (op == OP_STATUS_RD) || (op == OP_SEC_RD); // R8 R9 R11 R13
    end else if (otp && ((op == SR_WR_OP) || (op == SEC_WR_OP))) begin
      ok = 1'b0; // R23
    end else if (otp && locked && ((op == OP_CONT_PROG) || (op == WRITE_ENABLE_CMD_OP))) begin
      ok = 1'b0; // R23
    end else if (((op == WAKE_OP) || (op == SIG_OP)) && write_in_progress) begin
      ok = 1'b0; // R18
    end else begin
      ok = known; // R25
    end
    cmd_ok = ok;
  endfunction : cmd_ok

  // pin synchroniser stages, bit order {cs, sclk, mosi}
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] pin_r; // filtered levels
  logic [2:0] pin_d_r; // filtered levels one cycle late
  logic [2:0] pin_nxt;

  // frame state
  logic [2:0] bit_cnt_r;
  logic [3:0] byte_cnt_r; // saturates at 15
  logic [6:0] shift_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  logic [15:0] data_r;
  logic par_r; // id alternation
  logic [7:0] tx_sh_r;
  logic miso_r;
  logic oe_n_r;

  // mode state
  logic wel_r;
  logic cp_r;
  logic [23:0] cp_addr_r;
  logic [23:0] target_r;
  logic rb_en_r;
  logic otp_r;
  logic prog_req_r;
  logic [23:0] prog_addr_r;
  logic [15:0] prog_data_r;
  logic srw_req_r;
  logic [7:0] reg_wdata_r;
  logic scw_req_r;
  power_type pwr_r;
  power_type pwr_nxt;
  logic [11:0] timer_r;
  logic [11:0] timer_nxt;
  logic [7:0] sec_w;

  // a change counts once the second and third stages agree
  assign pin_nxt = (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));

  // synchronisers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sync1_r <= PIN_RST;
      sync2_r <= PIN_RST;
      sync3_r <= PIN_RST;
      pin_r <= PIN_RST;
      pin_d_r <= PIN_RST;
    end else begin
      sync1_r <= {spi_cs_n_i, spi_sclk_i, spi_mosi_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= pin_nxt;
      pin_d_r <= pin_r;
    end
  end

  // edge decoding on the filtered levels
  wire cs_n = pin_r[2];
  wire mosi = pin_r[0];
  wire cs_fall = pin_d_r[2] & ~pin_r[2];
  wire cs_rise = ~pin_d_r[2] & pin_r[2];
  wire sclk_rise = ~pin_d_r[1] & pin_r[1] & ~cs_n;
  wire sclk_fall = pin_d_r[1] & ~pin_r[1] & ~cs_n;
  wire [7:0] rx_byte = {shift_r, mosi};
  wire byte_done = sclk_rise && (bit_cnt_r == 3'd7);

  // mode decode
  wire asleep = (pwr_r != PWR_STANDBY);
  wire waking = (pwr_r == PWR_WAKING);
  wire op_seen = (byte_cnt_r != 4'd0);
  wire acc_w = op_seen && cmd_ok(op_r, cp_r, asleep, waking, write_in_progress_i, otp_r, otp_locked_i);
  wire exact8 = (byte_cnt_r == 4'd1) && (bit_cnt_r == 3'd0);
  wire exact16 = (byte_cnt_r == 4'd2) && (bit_cnt_r == 3'd0);
  wire end_ok = cs_rise && acc_w;
  // later pairs carry no address
  wire [3:0] hdr = cp_r ? HDR_NEXT : HDR_FIRST; // R6 R10
  wire [3:0] hdr_p1 = hdr + 4'd1;
  wire [3:0] hdr_p2 = hdr + 4'd2;
  wire [23:0] odd_addr = {target_r[23:1], 1'b1};

  // frame-end events
  wire ev_write_enable_cmd = end_ok && (op_r == WRITE_ENABLE_CMD_OP) && exact8;
  wire ev_write_disable_cmd = end_ok && (op_r == OP_WRITE_DIS) && exact8;
  wire ev_cp = end_ok && (op_r == OP_CONT_PROG) && (byte_cnt_r >= hdr_p2) // R3
               && !area_protected_i && (cp_r || wel_r); // R1 R5
  wire ev_cp_last = ev_cp && (odd_addr >= last_unprotected_addr_i); // R7
  wire ev_sleep = end_ok && (op_r == SLEEP_OP) && exact8;
  wire ev_wake = end_ok && (((op_r == WAKE_OP) && exact8) // R16
                            || ((op_r == SIG_OP) && (byte_cnt_r >= SIG_DONE_BYTES))); // R19
  wire ev_otp_in = end_ok && (op_r == OTP_IN_OP) && exact8;
  wire ev_otp_out = end_ok && (op_r == OTP_OUT_OP) && exact8;
  wire ev_rb_en = end_ok && (op_r == RB_EN_OP) && exact8;
  wire ev_rb_dis = end_ok && (op_r == RB_DIS_OP) && exact8;
  wire ev_srw = end_ok && (op_r == SR_WR_OP) && exact16 && wel_r;
  wire ev_scw = end_ok && (op_r == SEC_WR_OP) && exact8;

  // read data selection
  wire id_dev_first = (addr_r[7:0] == ID_ADDR_DEV_FIRST);
  wire tx_op = (op_r == OP_STATUS_RD) || (op_r == OP_SEC_RD) || (op_r == SIG_OP) || is_id(op_r);
  wire [3:0] tx_start = ((op_r == OP_STATUS_RD) || (op_r == OP_SEC_RD)) ? TX_START_REG : TX_START_ID;
  wire tx_on = acc_w && tx_op && (byte_cnt_r >= tx_start);
  wire [7:0] tx_byte = (op_r == OP_STATUS_RD) ? status_byte_i :
                       (op_r == OP_SEC_RD) ? sec_w :
                       (op_r == SIG_OP) ? SIG_ID : // R19
                       (par_r ^ id_dev_first) ? DEV_ID : MAN_ID; // R20 R21
  wire rb_active = rb_en_r && cp_r && !cs_n; // R12

  // security register view, reserved bits zero
  always_comb begin
    sec_w = 8'h00;
    sec_w[SEC_CP_BIT] = cp_r; // R24
    sec_w[SEC_LOCK_BIT] = otp_locked_i;
    sec_w[SEC_FACTORY_BIT] = otp_factory_lock_i;
  end

  // bit and byte capture on rising serial clock, mode 0
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bit_cnt_r <= 3'd0;
      byte_cnt_r <= 4'd0;
      shift_r <= 7'h00;
      op_r <= 8'h00;
      addr_r <= ADDR_RST;
      data_r <= 16'h0000;
      par_r <= 1'b0;
    end else if (cs_fall) begin
      // fresh frame
      bit_cnt_r <= 3'd0;
      byte_cnt_r <= 4'd0;
      par_r <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'd1;
      shift_r <= {shift_r[5:0], mosi};
      if (byte_done) begin
        if (byte_cnt_r != 4'hf) begin
          byte_cnt_r <= byte_cnt_r + 4'd1;
        end
        if (byte_cnt_r == 4'd0) begin
          op_r <= rx_byte;
        end
        if ((byte_cnt_r >= 4'd1) && (byte_cnt_r <= 4'd3)) begin
          addr_r <= {addr_r[15:0], rx_byte}; // msb byte first
        end
        if (byte_cnt_r == hdr) begin
          data_r[15:8] <= rx_byte; // R2
        end
        if (byte_cnt_r == hdr_p1) begin
          data_r[7:0] <= rx_byte; // R2 R4
        end
        if (byte_cnt_r >= TX_START_ID) begin
          par_r <= ~par_r; // R21
        end
      end
    end
  end

  // serial output: shifted on falling clock, or ready busy level
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      miso_r <= 1'b0;
      oe_n_r <= 1'b1;
      tx_sh_r <= 8'h00;
    end else if (cs_n) begin
      oe_n_r <= 1'b1; // R12
    end else if (rb_active) begin
      miso_r <= ~write_in_progress_i; // R12
      oe_n_r <= 1'b0;
    end else if (sclk_fall) begin
      if (tx_on && (bit_cnt_r == 3'd0)) begin
        miso_r <= tx_byte[7]; // R20
        tx_sh_r <= {tx_byte[6:0], 1'b0};
        oe_n_r <= 1'b0;
      end else if (tx_on) begin
        miso_r <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        oe_n_r <= 1'b0;
      end else begin
        oe_n_r <= 1'b1;
      end
    end
  end

  // write enable latch; a set beats a simultaneous clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wel_r <= 1'b0;
    end else if (ev_write_enable_cmd) begin
      wel_r <= 1'b1; // R1
    end else if (ev_write_disable_cmd || ev_cp_last || wel_clear_i) begin
      wel_r <= 1'b0; // R7
    end
  end

  // pair program mode and its running address
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cp_r <= 1'b0;
      cp_addr_r <= ADDR_RST;
      target_r <= ADDR_RST;
    end else begin
      // even address of the pair; settled well before select rises
      target_r <= cp_r ? cp_addr_r : {addr_r[23:1], 1'b0};
      if (ev_cp_last || ev_write_disable_cmd) begin
        cp_r <= 1'b0; // R7 R9
      end else if (ev_cp) begin
        cp_r <= 1'b1;
        cp_addr_r <= target_r + 24'd2; // R6
      end
    end
  end

  // program request toward the array, one cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prog_req_r <= 1'b0;
      prog_addr_r <= ADDR_RST;
      prog_data_r <= 16'h0000;
    end else begin
      prog_req_r <= ev_cp;
      if (ev_cp) begin
        prog_addr_r <= target_r; // R2
        prog_data_r <= data_r;
      end
    end
  end

  // register write requests
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      srw_req_r <= 1'b0;
      scw_req_r <= 1'b0;
      reg_wdata_r <= 8'h00;
    end else begin
      srw_req_r <= ev_srw; // R23
      scw_req_r <= ev_scw; // R23
      if (ev_srw) begin
        reg_wdata_r <= addr_r[7:0];
      end
    end
  end

  // ready busy enable and otp window flags
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rb_en_r <= 1'b0;
      otp_r <= 1'b0;
    end else begin
      if (ev_rb_en) begin
        rb_en_r <= 1'b1; // R13
      end else if (ev_rb_dis) begin
        rb_en_r <= 1'b0; // R13
      end
      if (ev_otp_in) begin
        otp_r <= 1'b1; // R22
      end else if (ev_otp_out) begin
        otp_r <= 1'b0; // R22
      end
    end
  end

  // power state sequencing
  always_comb begin
    pwr_nxt = pwr_r;
    timer_nxt = (timer_r == 12'd0) ? 12'd0 : timer_r - 12'd1;
    case (pwr_r)
      PWR_STANDBY: begin
        if (ev_sleep) begin
          pwr_nxt = PWR_ENTERING; // R14
          timer_nxt = SLEEP_ENTRY_CYC - 12'd1;
        end
      end
      PWR_ENTERING, PWR_DEEP: begin
        if (ev_wake) begin
          pwr_nxt = PWR_WAKING; // R17
          timer_nxt = WAKE_CYC - 12'd1;
        end else if ((pwr_r == PWR_ENTERING) && (timer_r == 12'd0)) begin
          pwr_nxt = PWR_DEEP; // R14
        end
      end
      PWR_WAKING: begin
        if (timer_r == 12'd0) begin
          pwr_nxt = PWR_STANDBY; // R17
        end
      end
      default: begin
        pwr_nxt = PWR_STANDBY;
      end
    endcase
  end

  // power state registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pwr_r <= PWR_STANDBY;
      timer_r <= 12'd0;
    end else begin
      pwr_r <= pwr_nxt;
      timer_r <= timer_nxt;
    end
  end

  // outputs
  assign spi_miso_o = miso_r;
  assign spi_miso_oe_n_o = oe_n_r;
  assign target_addr_o = target_r;
  assign prog_req_o = prog_req_r;
  assign prog_addr_o = prog_addr_r;
  assign prog_data_o = prog_data_r;
  assign status_write_req_o = srw_req_r;
  assign reg_wdata_o = reg_wdata_r;
  assign sec_write_req_o = scw_req_r;
  assign write_enable_latch_o = wel_r;
  assign cp_mode_o = cp_r;
  assign ready_busy_en_o = rb_en_r;
  assign otp_mode_o = otp_r;
  assign deep_sleep_o = (pwr_r == PWR_DEEP);
  assign security_reg_o = sec_w;

endmodule : flash_cmd_core

// ### tb/flash_cmd_checker_assertions.sv
// port-level assertion checker for the flash instruction handler
`timescale 1ns/10ps
module flash_cmd_checker
  import flash_cmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_n_o,
  input wire logic write_in_progress_i,
  input wire logic [23:0] last_unprotected_addr_i,
  input wire logic prog_req_o,
  input wire logic [23:0] prog_addr_o,
  input wire logic status_write_req_o,
  input wire logic sec_write_req_o,
  input wire logic write_enable_latch_o,
  input wire logic cp_mode_o,
  input wire logic ready_busy_en_o,
  input wire logic deep_sleep_o,
  input wire logic [7:0] security_reg_o
);
  logic [11:0] cs_hi_r; // cycles since the select pin last rose
  logic [11:0] cs_hi_nxt;
  // busy flag belongs on the pin while selected in pair mode
  wire logic rb_on = ready_busy_en_o && cp_mode_o && !spi_cs_n_i;
  // saturating count, so a long idle never wraps back below the entry delay
  assign cs_hi_nxt = spi_cs_n_i ? (cs_hi_r + {11'h000, ~&cs_hi_r}) : 12'h000;
  // counter register, cleared by reset
  always_ff @(posedge mclk_i) begin
    cs_hi_r <= rst_n_i ? cs_hi_nxt : 12'h000;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_oe_idle; spi_cs_n_i [*6] |-> spi_miso_oe_n_o; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
  property p_rb_ready; (rb_on && !write_in_progress_i) [*8] |-> !spi_miso_oe_n_o && spi_miso_o; endproperty
  a_rb_ready: assert property (p_rb_ready) else $error("ready level missing");
  property p_prog_even; prog_req_o |-> !prog_addr_o[0]; endproperty
  a_prog_even: assert property (p_prog_even) else $error("pair address odd");
  property p_prog_wel; prog_req_o |-> $past(write_enable_latch_o) || $past(cp_mode_o); endproperty
  a_prog_wel: assert property (p_prog_wel) else $error("program without latch");
  property p_last;
    prog_req_o && ((prog_addr_o | 24'h000001) >= last_unprotected_addr_i) |-> !cp_mode_o && !write_enable_latch_o;
  endproperty
  a_last: assert property (p_last) else $error("pair mode kept at top");
  property p_cp_bit; security_reg_o[SEC_CP_BIT] == cp_mode_o; endproperty
  a_cp_bit: assert property (p_cp_bit) else $error("mode bit wrong");
  property p_rb_hold; cp_mode_o |=> $stable(ready_busy_en_o); endproperty
  a_rb_hold: assert property (p_rb_hold) else $error("busy enable changed in pair mode");
  property p_deep_quiet; deep_sleep_o |-> !prog_req_o && !status_write_req_o && !sec_write_req_o; endproperty
  a_deep_quiet: assert property (p_deep_quiet) else $error("write while asleep");
  property p_entry; $rose(deep_sleep_o) |-> cs_hi_r >= SLEEP_ENTRY_CYC; endproperty
  a_entry: assert property (p_entry) else $error("sleep entered early");
  c_pair: cover property (prog_req_o && cp_mode_o);
  c_deep: cover property ($rose(deep_sleep_o));
  c_rb: cover property (rb_on && !spi_miso_oe_n_o);
endmodule : flash_cmd_checker

bind flash_cmd_core flash_cmd_checker u_chk (
  .mclk_i, .rst_n_i, .spi_cs_n_i, .spi_miso_o, .spi_miso_oe_n_o, .write_in_progress_i,
  .last_unprotected_addr_i, .prog_req_o, .prog_addr_o, .status_write_req_o, .sec_write_req_o,
  .write_enable_latch_o, .cp_mode_o, .ready_busy_en_o, .deep_sleep_o, .security_reg_o
);

// ### tb/host_model.sv
// host serial controller model, mode 0, one instruction per select frame
`timescale 1ns/10ps
module host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  // idle: deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // all pin changes land on falling mclk edges
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick
  // raw select control, used to watch the busy flag without clocks
  task automatic sel(input logic on);
    cs_n_o = ~on;
    tick(on ? 0 : 16);
  endtask : sel
  // send tx msb first, then clock in nrd bytes; 4 mclk per half period
  task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [15:0] rd);
    logic [7:0] b;
    rd = 16'h0000;
    tick(1);
    cs_n_o = 1'b0;
    for (int i = 0; i < tx.size() + nrd; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'hff;
      for (int k = 7; k >= 0; k--) begin
        mosi_o = b[k];
        tick(4);
        sclk_o = 1'b1;
        tick(4);
        // slow host: samples late in the high half, the pin filter adds delay
        if (i >= tx.size()) rd = {rd[14:0], miso_i};
        sclk_o = 1'b0;
      end
    end
    tick(4);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line shows no stale value
    tick(16);
  endtask : frame
endmodule : host_model

// ### tb/test_flash_cmd_core.sv
// self-checking bench for the flash instruction handler
`timescale 1ns/10ps
module test_flash_cmd_core;
  import flash_cmd_pkg::*;
  logic mclk = 1'b0; // 20 MHz system clock
  logic rst_n = 1'b0;
  logic write_in_progress = 1'b0; // array engine busy
  logic prot = 1'b0; // target area protected
  logic [23:0] last = 24'hffffff; // top unprotected byte
  logic lock = 1'b0; // otp region locked down
  logic cs_n, sclk, mosi, miso, oe_n, preq, swreq, screq, write_enable_latch, cp, rben, otp, deep;
  logic [23:0] paddr;
  logic [15:0] pdata, rd;
  logic [7:0] wdata, sec;
  logic [7:0] idop [3] = '{OP_ID_PAIR, OP_ID_PAIR2, OP_ID_PAIR4};
  int err_count = 0;
  int checks = 0;
  int npr = 0; // program pulses seen
  int nsw = 0; // status write pulses seen
  int nsc = 0; // security write pulses seen
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
$display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
  always #25 mclk = ~mclk;
  // one-cycle pulses are counted so none slips between checks
  always @(posedge mclk) begin
    npr += int'(preq === 1'b1);
    nsw += int'(swreq === 1'b1);
    nsc += int'(screq === 1'b1);
  end
  flash_cmd_core u_dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .write_in_progress_i(write_in_progress), .wel_clear_i(1'b0),
    .area_protected_i(prot), .last_unprotected_addr_i(last), .otp_locked_i(lock),
    .otp_factory_lock_i(1'b0), .status_byte_i(8'h5c), .target_addr_o(), .prog_req_o(preq),
    .prog_addr_o(paddr), .prog_data_o(pdata), .status_write_req_o(swreq), .reg_wdata_o(wdata),
    .sec_write_req_o(screq), .write_enable_latch_o(write_enable_latch), .cp_mode_o(cp), .ready_busy_en_o(rben),
    .otp_mode_o(otp), .deep_sleep_o(deep), .security_reg_o(sec)
  );
  host_model u_host (.mclk_i(mclk), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  // write-only frame
  task automatic h(input logic [7:0] q[$]);
    u_host.frame(q, 0, rd);
  endtask : h
  task automatic summarize();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // hang guard: every wait below is fixed, this bounds the whole run
  initial begin
    repeat (30000) @(posedge mclk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    tick(4);
    `CHK(oe_n, 1'b1)
    h('{OP_CONT_PROG, 8'h00, 8'h00, 8'h10, 8'h11, 8'h22});
    `CHK(npr, 0)
    h('{DEF_OP_RB_EN});
    `CHK(rben, 1'b1)
    h('{DEF_OP_WRITE_ENABLE_CMD});
    `CHK(write_enable_latch, 1'b1)
    // odd start address, a third data byte
    h('{OP_CONT_PROG, 8'h00, 8'h00, 8'h11, 8'h5a, 8'ha5, 8'hcc});
    `CHK(npr, 1)
    `CHK(paddr, 24'h000010)
    `CHK(pdata, 16'h5aa5)
    `CHK(sec[SEC_CP_BIT], 1'b1)
    h('{OP_CONT_PROG, 8'h77});
    `CHK(npr, 1)
    h('{OP_CONT_PROG, 8'h12, 8'h34});
    `CHK(paddr, 24'h000012)
    `CHK(pdata, 16'h1234)
    h('{DEF_OP_RB_DIS});
    `CHK(rben, 1'b1)
    h('{DEF_OP_OTP_IN});
    `CHK(otp, 1'b0)
    // busy then ready on the output pin while selected
    write_in_progress = 1'b1;
    u_host.sel(1'b1);
    tick(10);
    `CHK(oe_n, 1'b0)
    `CHK(miso, 1'b0)
    write_in_progress = 1'b0;
    tick(10);
    `CHK(miso, 1'b1)
    u_host.sel(1'b0);
    `CHK(oe_n, 1'b1)
    write_in_progress = 1'b1;
    h('{OP_WRITE_DIS});
    `CHK(cp, 1'b1)
    write_in_progress = 1'b0;
    h('{OP_WRITE_DIS});
    `CHK(cp, 1'b0)
    `CHK(write_enable_latch, 1'b0)
    h('{DEF_OP_RB_DIS});
    `CHK(rben, 1'b0)
    h('{DEF_OP_WRITE_ENABLE_CMD});
    prot = 1'b1;
    h('{OP_CONT_PROG, 8'h00, 8'h00, 8'h20, 8'h11, 8'h22});
    `CHK(npr, 2)
    `CHK(write_enable_latch, 1'b1)
    prot = 1'b0;
    last = 24'h000021;
    h('{OP_CONT_PROG, 8'h00, 8'h00, 8'h20, 8'h66, 8'h77});
    `CHK(npr, 3)
    `CHK(cp, 1'b0)
    `CHK(write_enable_latch, 1'b0)
    last = 24'hffffff;
    // a status read after the mode has ended returns the status byte
    u_host.frame('{OP_STATUS_RD}, 1, rd);
    `CHK(rd, 16'h005c)
    // every id opcode, both orders
    foreach (idop[i]) begin
      for (int a = 0; a < 2; a++) begin
        u_host.frame('{idop[i], 8'h00, 8'h00, 8'(a)}, 2, rd);
        `CHK(rd, (a == 1) ? {DEF_DEV_ID, DEF_MAN_ID} : {DEF_MAN_ID, DEF_DEV_ID})
      end
    end
    u_host.frame('{DEF_OP_SIG, 8'h00, 8'h00, 8'h00}, 2, rd);
    `CHK(rd, {DEF_SIG_ID, DEF_SIG_ID})
    h('{DEF_OP_SLEEP});
    tick(30);
    `CHK(deep, 1'b0)
    tick(30);
    `CHK(deep, 1'b1)
    h('{DEF_OP_WRITE_ENABLE_CMD});
    `CHK(write_enable_latch, 1'b0)
    write_in_progress = 1'b1;
    h('{DEF_OP_WAKE});
    `CHK(deep, 1'b1)
    write_in_progress = 1'b0;
    h('{DEF_OP_WAKE, 8'h00});
    `CHK(deep, 1'b1)
    h('{DEF_OP_WAKE});
    `CHK(deep, 1'b0)
    h('{DEF_OP_WRITE_ENABLE_CMD});
    `CHK(write_enable_latch, 1'b0)
    tick(180);
    h('{DEF_OP_WRITE_ENABLE_CMD});
    `CHK(write_enable_latch, 1'b1)
    h('{DEF_OP_OTP_IN});
    `CHK(otp, 1'b1)
    h('{DEF_OP_SR_WR, 8'h3c});
    `CHK(nsw, 0)
    h('{DEF_OP_SEC_WR});
    `CHK(nsc, 0)
    h('{DEF_OP_OTP_OUT});
    `CHK(otp, 1'b0)
    h('{DEF_OP_SR_WR, 8'h3c});
    `CHK(nsw, 1)
    `CHK(wdata, 8'h3c)
    h('{DEF_OP_SEC_WR});
    `CHK(nsc, 1)
    // locked region: the latch is still set, yet a pair must not program
    lock = 1'b1;
    h('{DEF_OP_OTP_IN});
    `CHK(sec[SEC_LOCK_BIT], 1'b1)
    h('{OP_CONT_PROG, 8'h00, 8'h00, 8'h40, 8'h01, 8'h02});
    `CHK(npr, 3)
    summarize();
  end
endmodule : test_flash_cmd_core
